// ===== verilog/bwr_regulator.sv
// bandwidth regulator with priority handling for a memory system component
`default_nettype none
module bwr_regulator #(
   parameter int NP = 4,
   parameter int PW = 2,
   parameter int PRIO_W = 4,
   parameter int COST_W = 8,
   parameter int USE_W = 24,
   parameter int CNT_W = 24,
   parameter int PASS_W = 32,
   parameter int HIST_LOG = 2,
   parameter bit HAS_STRIDE = 1'b1,
   parameter bit HAS_INT_PRIO = 1'b1,
   parameter bit HAS_DS_PRIO = 1'b1,
   parameter bit WINWD_SETTABLE = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire bwr_pkg::bwr_mode_type mode_i,
   input wire logic [7:0] avail_bw_i,
   input wire logic [NP-1:0] req_valid_i,
   input wire logic [NP-1:0][PRIO_W-1:0] req_prio_i,
   input wire logic [NP-1:0][COST_W-1:0] req_cost_i,
   output logic [NP-1:0] req_ready_o,
   output logic ds_valid_o,
   input wire logic ds_ready_i,
   output logic [PW-1:0] ds_partition_identifier_o,
   output logic [PRIO_W-1:0] ds_prio_o,
   output logic [COST_W-1:0] ds_cost_o,
   input wire logic rsp_valid_i,
   input wire logic [PRIO_W-1:0] rsp_prio_i,
   output logic rsp_valid_o,
   output logic [PRIO_W-1:0] rsp_prio_o,
   input wire logic [PW-1:0] partition_selector_i,
   input wire logic cfg_wr_i,
   input wire logic [15:0] cfg_min_i,
   input wire logic [15:0] cfg_max_i,
   input wire logic cfg_hard_limit_i,
   input wire logic [15:0] cfg_window_width_i,
   input wire logic [15:0] cfg_stride_minus_one_i,
   input wire logic cfg_stride_enable_i,
   input wire logic [PRIO_W-1:0] cfg_int_prio_i,
   input wire logic [PRIO_W-1:0] cfg_ds_prio_i,
   output logic [15:0] window_width_setting_o,
   output logic [USE_W-1:0] sel_usage_o,
   output logic stride_control_present_o
);
   import bwr_pkg::*;

   logic [15:0] min_reg [NP];
   logic [15:0] max_reg [NP];
   logic hard_limit_reg [NP];
   logic [15:0] winwd_reg [NP];
   logic [15:0] stride_reg [NP];
   logic stride_enable_reg [NP];
   logic [PRIO_W-1:0] iprio_reg [NP];
   logic [PRIO_W-1:0] dsprio_reg [NP];
   logic [PASS_W-1:0] pass_reg [NP];
   logic [USE_W-1:0] thr_min [NP];
   logic [USE_W-1:0] thr_max [NP];
   logic [CNT_W-1:0] slice_len [NP];
   bwr_pref_type pref [NP];
   logic [USE_W-1:0] usage [NP];
   logic [PRIO_W-1:0] key [NP];
   logic [PW-1:0] win;
   logic found;
   logic accept;
   logic grant_any;
   logic ds_valid_reg;
   bwr_pref_type top_pref;

   function automatic logic [USE_W-1:0] frac_thr(input logic [15:0] frac,
                                                 input logic [7:0] avail,
                                                 input logic [CNT_W-1:0] cyc);
      logic [47:0] prod;
      prod = 48'(frac) * 48'(avail) * 48'(cyc);
      if (|prod[47:FRAC_W+USE_W]) begin
         frac_thr = '1;
      end else begin
         frac_thr = prod[FRAC_W+USE_W-1:FRAC_W];
      end
   endfunction : frac_thr

   // configuration for the selected partition
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int p = 0; p < NP; p++) begin
            min_reg[p] <= MIN_RESET;
            max_reg[p] <= MAX_RESET;
            hard_limit_reg[p] <= 1'b0;
            winwd_reg[p] <= WINWD_RESET;
            stride_reg[p] <= STRIDE_RESET;
            stride_enable_reg[p] <= 1'b0;
            iprio_reg[p] <= '0;
            dsprio_reg[p] <= '0;
         end
      end else if (cfg_wr_i) begin
         min_reg[partition_selector_i] <= cfg_min_i;
         max_reg[partition_selector_i] <= cfg_max_i;
         hard_limit_reg[partition_selector_i] <= cfg_hard_limit_i;
         if (WINWD_SETTABLE) begin
            winwd_reg[partition_selector_i] <= cfg_window_width_i;
         end
         stride_reg[partition_selector_i] <= cfg_stride_minus_one_i;
         stride_enable_reg[partition_selector_i] <= cfg_stride_enable_i;
         iprio_reg[partition_selector_i] <= cfg_int_prio_i;
         dsprio_reg[partition_selector_i] <= cfg_ds_prio_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         window_width_setting_o <= WINWD_RESET;
         sel_usage_o <= '0;
      end else begin
         window_width_setting_o <= winwd_reg[partition_selector_i];
         sel_usage_o <= usage[partition_selector_i];
      end
   end

   assign stride_control_present_o = HAS_STRIDE;

   for (genvar p = 0; p < NP; p++) begin : g_part
      logic [CNT_W-1:0] win_cyc;
      logic [31:0] cyc_full;
      assign cyc_full = (32'(winwd_reg[p]) * 32'(CYC_PER_US)) >> WINWD_FRAC;
      assign win_cyc = CNT_W'(cyc_full);
      assign slice_len[p] = ((win_cyc >> HIST_LOG) == '0) ? CNT_W'(1) : (win_cyc >> HIST_LOG);
      // each partition scaled on its own, no cap on totals
      assign thr_min[p] = frac_thr(min_reg[p], avail_bw_i, win_cyc);
      assign thr_max[p] = frac_thr(max_reg[p], avail_bw_i, win_cyc);
      assign key[p] = HAS_INT_PRIO ? iprio_reg[p] : req_prio_i[p];

      bwr_part #(
         .USE_W(USE_W),
         .CNT_W(CNT_W),
         .COST_W(COST_W),
         .HIST_LOG(HIST_LOG)
      ) u_part (
         .clk_i(clk_i),
         .rst_b_i(rst_b_i),
         .mode_i(mode_i),
         .slice_len_i(slice_len[p]),
         .thr_min_i(thr_min[p]),
         .thr_max_i(thr_max[p]),
         .hard_i(hard_limit_reg[p]),
         .grant_i(req_ready_o[p]),
         .cost_i(req_cost_i[p]),
         .pref_o(pref[p]),
         .usage_o(usage[p])
      );
   end

   // pick the best eligible request
   always_comb begin
      logic better;
      better = 1'b0;
      win = '0;
      found = 1'b0;
      top_pref = BWR_PREF_NONE;
      for (int p = 0; p < NP; p++) begin
         better = 1'b0;
         if (req_valid_i[p] && pref[p] != BWR_PREF_NONE) begin
            if (!found || pref[p] > pref[win]) begin
               better = 1'b1;
            end else if (pref[p] == pref[win]) begin
               if (HAS_STRIDE && stride_enable_reg[p] && stride_enable_reg[win]) begin
                  better = pass_reg[p] < pass_reg[win];
               end else begin
                  better = key[p] > key[win];
               end
            end
         end
         if (better) begin
            win = PW'(p);
            found = 1'b1;
            top_pref = pref[p];
         end
      end
   end

   assign accept = !ds_valid_reg || ds_ready_i;
   assign grant_any = found && accept;

   always_comb begin
      req_ready_o = '0;
      if (grant_any) begin
         req_ready_o[win] = 1'b1;
      end
   end

   // stride pass advances by stride on each grant to a partition with stride enabled
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int p = 0; p < NP; p++) begin
            pass_reg[p] <= '0;
         end
      end else if (grant_any && stride_enable_reg[win]) begin
         pass_reg[win] <= pass_reg[win] + PASS_W'(stride_reg[win]) + PASS_W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ds_valid_reg <= 1'b0;
         ds_partition_identifier_o <= '0;
         ds_prio_o <= '0;
         ds_cost_o <= '0;
      end else if (grant_any) begin
         ds_valid_reg <= 1'b1;
         ds_partition_identifier_o <= win;
         if (HAS_DS_PRIO) begin
            ds_prio_o <= dsprio_reg[win];
         end else begin
            ds_prio_o <= req_prio_i[win];
         end
         ds_cost_o <= req_cost_i[win];
      end else if (ds_ready_i) begin
         ds_valid_reg <= 1'b0;
      end
   end

   assign ds_valid_o = ds_valid_reg;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rsp_valid_o <= 1'b0;
         rsp_prio_o <= '0;
      end else begin
         rsp_valid_o <= rsp_valid_i;
         rsp_prio_o <= rsp_prio_i;
      end
   end

   sequence s_grant;
      grant_any;
   endsequence

   sequence s_issue;
      ds_valid_o && ds_partition_identifier_o == $past(win);
   endsequence

   property p_ds_prio;
      @(posedge clk_i) disable iff (!rst_b_i)
      s_grant |=> s_issue and
         (ds_prio_o == (HAS_DS_PRIO ? $past(dsprio_reg[win]) : $past(req_prio_i[win])));
   endproperty
   a_ds_prio: assert property (p_ds_prio) else $error("downstream priority wrong");

   property p_through_prio;
      @(posedge clk_i) disable iff (!rst_b_i)
      (!HAS_DS_PRIO && grant_any) |=> ds_prio_o == $past(req_prio_i[win]);
   endproperty
   a_through_prio: assert property (p_through_prio) else $error("priority not passed");

   property p_rsp_prio;
      @(posedge clk_i) disable iff (!rst_b_i)
      rsp_valid_i |=> rsp_valid_o && rsp_prio_o == $past(rsp_prio_i);
   endproperty
   a_rsp_prio: assert property (p_rsp_prio) else $error("response priority altered");

   // any waiting request with a better preference than the winner
   logic higher_waiting;
   always_comb begin
      higher_waiting = 1'b0;
      for (int p = 0; p < NP; p++) begin
         if (req_valid_i[p] && pref[p] > pref[win]) begin
            higher_waiting = 1'b1;
         end
      end
   end

   property p_pref_order;
      @(posedge clk_i) disable iff (!rst_b_i)
      grant_any |-> pref[win] == top_pref && top_pref != BWR_PREF_NONE && !higher_waiting;
   endproperty
   a_pref_order: assert property (p_pref_order) else $error("preference order broken");

   sequence s_wr_sel;
      WINWD_SETTABLE && cfg_wr_i ##1 partition_selector_i == $past(partition_selector_i);
   endsequence

   property p_winwd_rd;
      @(posedge clk_i) disable iff (!rst_b_i)
      s_wr_sel |=> window_width_setting_o == $past(cfg_window_width_i, 2);
   endproperty
   a_winwd_rd: assert property (p_winwd_rd) else $error("window width readback wrong");

   property p_stride_adv;
      @(posedge clk_i) disable iff (!rst_b_i)
      (grant_any && stride_enable_reg[win]) |=>
         pass_reg[$past(win)] == $past(pass_reg[win]) + PASS_W'($past(stride_reg[win])) + PASS_W'(1);
   endproperty
   a_stride_adv: assert property (p_stride_adv) else $error("stride pass not advanced");

   sequence s_stalled;
      ds_valid_o && !ds_ready_i;
   endsequence

   // no grant while stalled, and the request stands into the next cycle
   property p_hold_ds;
      @(posedge clk_i) disable iff (!rst_b_i)
      s_stalled |-> (req_ready_o == '0) ##1 (ds_valid_o && $stable(ds_cost_o));
   endproperty
   a_hold_ds: assert property (p_hold_ds) else $error("downstream request dropped");
endmodule : bwr_regulator
`default_nettype wire

// ===== verilog/bwr_pkg.sv
// constants and types for the bandwidth regulator
`default_nettype none
package bwr_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS = 1000;
   localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
   localparam int FRAC_W = 16;
   localparam int WINWD_FRAC = 8;
   localparam logic [FRAC_W-1:0] MAX_RESET = 16'hffff;
   localparam logic [FRAC_W-1:0] MIN_RESET = 16'h0000;
   localparam logic [15:0] WINWD_RESET = 16'h0a00;
   localparam logic [15:0] STRIDE_RESET = 16'h0000;

   typedef enum logic [1:0] {
      BWR_MODE_FIXED = 2'b00,
      BWR_MODE_MOVING = 2'b01,
      BWR_MODE_DECAY = 2'b10
   } bwr_mode_type;

   typedef enum logic [1:0] {
      BWR_PREF_NONE = 2'b00,
      BWR_PREF_LOW = 2'b01,
      BWR_PREF_MED = 2'b10,
      BWR_PREF_HIGH = 2'b11
   } bwr_pref_type;
endpackage : bwr_pkg
`default_nettype wire

// ===== verilog/bwr_part.sv
// usage accounting and preference for one partition
`default_nettype none
module bwr_part #(
   parameter int USE_W = 24,
   parameter int CNT_W = 24,
   parameter int COST_W = 8,
   parameter int HIST_LOG = 2
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire bwr_pkg::bwr_mode_type mode_i,
   input wire logic [CNT_W-1:0] slice_len_i,
   input wire logic [USE_W-1:0] thr_min_i,
   input wire logic [USE_W-1:0] thr_max_i,
   input wire logic hard_i,
   input wire logic grant_i,
   input wire logic [COST_W-1:0] cost_i,
   output var bwr_pkg::bwr_pref_type pref_o,
   output logic [USE_W-1:0] usage_o
);
   import bwr_pkg::*;
   localparam int HIST = 1 << HIST_LOG;

   logic [CNT_W-1:0] slice_cnt_reg;
   logic [HIST_LOG-1:0] idx_reg;
   logic [USE_W-1:0] hist_reg [HIST];
   logic [USE_W-1:0] usage_reg;
   logic [USE_W-1:0] usage_next;
   logic tick;
   logic win_end;
   logic [HIST_LOG-1:0] idx_nx;
   logic [USE_W-1:0] add;
   logic [USE_W-1:0] sub;
   logic [USE_W-1:0] base;
   logic [USE_W:0] sum;

   assign tick = (slice_cnt_reg + CNT_W'(1)) >= slice_len_i;
   assign win_end = tick && (idx_reg == HIST_LOG'(HIST - 1));
   assign idx_nx = idx_reg + HIST_LOG'(1);
   assign add = grant_i ? USE_W'(cost_i) : '0;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         slice_cnt_reg <= '0;
         idx_reg <= '0;
      end else if (tick) begin
         slice_cnt_reg <= '0;
         idx_reg <= idx_nx;
      end else begin
         slice_cnt_reg <= slice_cnt_reg + CNT_W'(1);
      end
   end

   // command history in slices of the window
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < HIST; i++) begin
            hist_reg[i] <= '0;
         end
      end else if (tick) begin
         hist_reg[idx_nx] <= add;
      end else begin
         hist_reg[idx_reg] <= hist_reg[idx_reg] + add;
      end
   end

   always_comb begin
      sub = '0;
      base = usage_reg;
      if (mode_i == BWR_MODE_FIXED && win_end) begin
         base = '0;
      end
      if (mode_i == BWR_MODE_MOVING && tick) begin
         sub = hist_reg[idx_nx];
      end
      if (mode_i == BWR_MODE_DECAY && tick) begin
         sub = thr_max_i >> HIST_LOG;
      end
      base = (base > sub) ? base - sub : '0;
      sum = {1'b0, base} + {1'b0, add};
      usage_next = sum[USE_W] ? '1 : sum[USE_W-1:0];
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         usage_reg <= '0;
      end else begin
         usage_reg <= usage_next;
      end
   end

   always_comb begin
      if (usage_reg < thr_min_i) begin
         pref_o = BWR_PREF_HIGH;
      end else if (usage_reg < thr_max_i) begin
         pref_o = BWR_PREF_MED;
      end else if (hard_i) begin
         pref_o = BWR_PREF_NONE;
      end else begin
         pref_o = BWR_PREF_LOW;
      end
   end

   assign usage_o = usage_reg;

   property p_fixed_clear;
      @(posedge clk_i) disable iff (!rst_b_i)
      (mode_i == BWR_MODE_FIXED && win_end && !grant_i) |=> usage_reg == '0;
   endproperty
   a_fixed_clear: assert property (p_fixed_clear) else $error("window end kept usage");

   property p_no_wrap;
      @(posedge clk_i) disable iff (!rst_b_i)
      (grant_i && !tick) |=> usage_reg >= $past(usage_reg);
   endproperty
   a_no_wrap: assert property (p_no_wrap) else $error("usage wrapped");

   property p_decay_floor;
      @(posedge clk_i) disable iff (!rst_b_i)
      (mode_i == BWR_MODE_DECAY && tick && !grant_i && usage_reg <= (thr_max_i >> HIST_LOG))
      |=> usage_reg == '0;
   endproperty
   a_decay_floor: assert property (p_decay_floor) else $error("decay below zero");

   property p_hard_pref;
      @(posedge clk_i) disable iff (!rst_b_i)
      (hard_i && usage_reg >= thr_max_i && usage_reg >= thr_min_i) |-> pref_o == BWR_PREF_NONE;
   endproperty
   a_hard_pref: assert property (p_hard_pref) else $error("hard limit not applied");
endmodule : bwr_part
`default_nettype wire

// ===== sim/bwr_ds_model.sv
// downstream partner model: accepts requests and returns responses
`default_nettype none
module bwr_ds_model (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic stall_i,
   input wire logic ds_valid_i,
   output logic ds_ready_o,
   output logic rsp_valid_o,
   output logic [3:0] rsp_prio_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic took = 1'b0;
   logic [3:0] cnt = 4'h0;
   initial begin
      ds_ready_o = 1'b0;
      rsp_valid_o = 1'b0;
      rsp_prio_o = 4'h0;
   end
   // note a request taken at this edge
   always @(posedge clk_i) begin
      took <= rst_b_i && ds_valid_i && ds_ready_o;
   end
   // answer after the edge; idle priority lines show the inverse
   always @(negedge clk_i) begin
      ds_ready_o <= rst_b_i && !stall_i;
      rsp_valid_o <= took;
      rsp_prio_o <= took ? cnt : ~rsp_prio_o;
      if (took) begin
         cnt <= cnt + 4'h3;
      end
   end
endmodule : bwr_ds_model
`default_nettype wire

// ===== sim/bwr_regulator_tb.sv
// self-checking bench for the bandwidth regulator
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_mismatch++; \
   $display("BAD %s exp %0h got %0h", n, e, s); end end
module bwr_regulator_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bwr_pkg::*;
   logic clk_i = 1'b0, rst_b_i = 1'b0, stall = 1'b0, slow = 1'b0;
   bwr_mode_type mode_i = BWR_MODE_FIXED;
   logic [7:0] avail_bw_i = 8'h08;
   logic [3:0] req_valid_i = 4'h0, req_ready_o;
   logic [3:0][3:0] req_prio_i = 16'h0000;
   logic [3:0][7:0] req_cost_i = 32'h04040404;
   logic ds_valid_o, ds_ready_i, rsp_valid_i, rsp_valid_o, stride_control_present_o;
   logic [1:0] ds_partition_identifier_o, partition_selector_i = 2'h0;
   logic [3:0] ds_prio_o, rsp_prio_i, rsp_prio_o, ds_tab [4];
   logic [7:0] ds_cost_o;
   logic cfg_wr_i = 1'b0, cfg_hard_limit_i = 1'b0, cfg_stride_enable_i = 1'b0;
   logic [15:0] cfg_min_i = 16'h0000, cfg_max_i = 16'h0000, cfg_window_width_i = 16'h0000;
   logic [15:0] cfg_stride_minus_one_i = 16'h0000, window_width_setting_o;
   logic [3:0] cfg_int_prio_i = 4'h0, cfg_ds_prio_i = 4'h0;
   logic [23:0] sel_usage_o;
   logic [31:0] lfsr_q = 32'hc475;
   logic hl_watch = 1'b0, burst_chk = 1'b0;
   logic [14:0] dq [$], exp_d;
   logic [4:0] rq [$], exp_r;
   int n_mismatch = 0, samples_checked = 0, cnt [4], run, bursts;
   logic [3:0] req_ready2, ds_prio2;
   logic [1:0] ds_part2;
   logic ds_valid2, prop2, tie_watch = 1'b0;
   logic [15:0] wwid2;
   logic [6:0] pq [$], exp_p;

   bwr_regulator i_dut (.clk_i, .rst_b_i, .mode_i, .avail_bw_i, .req_valid_i, .req_prio_i,
      .req_cost_i, .req_ready_o, .ds_valid_o, .ds_ready_i, .ds_partition_identifier_o,
      .ds_prio_o, .ds_cost_o, .rsp_valid_i, .rsp_prio_i, .rsp_valid_o, .rsp_prio_o,
      .partition_selector_i, .cfg_wr_i, .cfg_min_i, .cfg_max_i, .cfg_hard_limit_i,
      .cfg_window_width_i, .cfg_stride_minus_one_i, .cfg_stride_enable_i, .cfg_int_prio_i,
      .cfg_ds_prio_i, .window_width_setting_o, .sel_usage_o, .stride_control_present_o);
   // variant without stride, internal or downstream priority and with fixed window width
   bwr_regulator #(.HAS_STRIDE(1'b0), .HAS_INT_PRIO(1'b0), .HAS_DS_PRIO(1'b0),
      .WINWD_SETTABLE(1'b0)) i_dut_thru (.clk_i, .rst_b_i, .mode_i, .avail_bw_i, .req_valid_i,
      .req_prio_i, .req_cost_i, .req_ready_o(req_ready2), .ds_valid_o(ds_valid2),
      .ds_ready_i(1'b1), .ds_partition_identifier_o(ds_part2), .ds_prio_o(ds_prio2),
      .ds_cost_o(), .rsp_valid_i, .rsp_prio_i, .rsp_valid_o(), .rsp_prio_o(),
      .partition_selector_i, .cfg_wr_i, .cfg_min_i, .cfg_max_i, .cfg_hard_limit_i,
      .cfg_window_width_i, .cfg_stride_minus_one_i, .cfg_stride_enable_i, .cfg_int_prio_i,
      .cfg_ds_prio_i, .window_width_setting_o(wwid2), .sel_usage_o(),
      .stride_control_present_o(prop2));
   bwr_ds_model i_ds (.clk_i, .rst_b_i, .stall_i(stall), .ds_valid_i(ds_valid_o),
      .ds_ready_o(ds_ready_i), .rsp_valid_o(rsp_valid_i), .rsp_prio_o(rsp_prio_i));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   // watcher: notes grants and responses, then checks what comes out
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         dq.delete();
         rq.delete();
         pq.delete();
      end else begin
         if (ds_valid2) begin
            exp_p = pq.size() > 0 ? pq.pop_front() : 7'h7f;
            `CHK("thru", exp_p, {1'b0, ds_part2, ds_prio2})
         end
         if (tie_watch && req_valid_i == 4'ha)
            `CHK("tie0", (req_prio_i[3] > req_prio_i[1]) ? 4'h8 : 4'h2, req_ready2)
         if (ds_valid_o && ds_ready_i) begin
            exp_d = dq.size() > 0 ? dq.pop_front() : 15'h7fff;
            `CHK("ds", exp_d, {1'b0, ds_partition_identifier_o, ds_prio_o, ds_cost_o})
         end
         for (int p = 0; p < 4; p++) begin
            if (req_ready_o[p] && req_valid_i[p]) begin
               dq.push_back({1'b0, 2'(p), ds_tab[p], req_cost_i[p]});
               cnt[p]++;
            end
            if (req_ready2[p]) begin
               pq.push_back({1'b0, 2'(p), req_prio_i[p]});
            end
         end
         if (burst_chk && req_ready_o[2]) begin
            run++;
         end else if (burst_chk && run > 0) begin
            if (bursts > 0) `CHK("burst", 5, run)
            bursts++;
            run = 0;
         end
         if (hl_watch) `CHK("use", 1'b1, sel_usage_o <= 24'h000077)
         if (rsp_valid_o) begin
            exp_r = rq.size() > 0 ? rq.pop_front() : 5'h10;
            `CHK("rsp", exp_r, {1'b0, rsp_prio_o})
         end
         if (rsp_valid_i) begin
            rq.push_back({1'b0, rsp_prio_i});
         end
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : cyc

   task automatic cfg(input logic [1:0] p, input logic [15:0] mn, mx, input logic hd, se,
                      input logic [15:0] sm1, input logic [3:0] ip, dp);
      partition_selector_i <= p;
      cfg_wr_i <= 1'b1;
      cfg_min_i <= mn;
      cfg_max_i <= mx;
      cfg_hard_limit_i <= hd;
      cfg_window_width_i <= 16'h0100;
      cfg_stride_minus_one_i <= sm1;
      cfg_stride_enable_i <= se;
      cfg_int_prio_i <= ip;
      cfg_ds_prio_i <= dp;
      ds_tab[p] = dp;
      cyc(1);
   endtask : cfg

   // reset, then one microsecond windows on every partition
   task automatic setup(input bwr_mode_type m);
      rst_b_i <= 1'b0;
      mode_i <= m;
      cyc(12);
      rst_b_i <= 1'b1;
      cyc(1);
      for (int p = 0; p < 4; p++) cfg(2'(p), 16'h0000, 16'hffff, 1'b0, 1'b0, 16'h0000,
         4'(p), 4'(p + 8));
   endtask : setup

   task automatic run_cnt(input logic [3:0] m, input int n);
      foreach (cnt[i]) cnt[i] = 0;
      for (int i = 0; i < n; i++) begin
         lfsr_q = lfsr(lfsr_q);
         req_valid_i <= m;
         req_prio_i <= lfsr_q[15:0];
         stall <= slow & lfsr_q[17] & lfsr_q[18];
         cyc(1);
      end
      req_valid_i <= 4'h0;
      stall <= 1'b0;
      cyc(4);
   endtask : run_cnt

   task automatic wrap_up;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      cyc(12);
      rst_b_i <= 1'b1;
      cyc(1);
      `CHK("wwid", 16'h0a00, window_width_setting_o)
      `CHK("prop", 1'b1, stride_control_present_o)
      `CHK("prop0", 1'b0, prop2)
      setup(BWR_MODE_FIXED);
      cfg(2'h0, 16'h2000, 16'h2000, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h8);
      cfg(2'h3, 16'h0000, 16'hffff, 1'b0, 1'b0, 16'h0000, 4'h3, 4'hb);
      cfg_wr_i <= 1'b0;
      cyc(2);
      `CHK("wwid", 16'h0100, window_width_setting_o)
      `CHK("wwid0", 16'h0a00, wwid2)
      run_cnt(4'h3, 3);
      `CHK("pref", {8'h03, 8'h00}, {8'(cnt[0]), 8'(cnt[1])})
      tie_watch = 1'b1;
      run_cnt(4'ha, 3);
      tie_watch = 1'b0;
      `CHK("tie", {8'h00, 8'h03}, {8'(cnt[1]), 8'(cnt[3])})
      slow = 1'b1;
      for (int e = 0; e < 3; e++) begin
         cfg(2'h1, 16'h0000, 16'hffff, 1'b0, e > 0, 16'h0000, 4'h1, 4'h9);
         cfg(2'h3, 16'h0000, 16'hffff, 1'b0, e > 1, 16'h0002, 4'h3, 4'hb);
         cfg_wr_i <= 1'b0;
         run_cnt(4'ha, 40);
         `CHK("stride", e > 1, cnt[1] > 0 && cnt[3] > 0)
      end
      slow = 1'b0;
      req_cost_i <= 32'h14141414;
      for (int m = 0; m < 3; m++) begin
         setup(bwr_mode_type'(m));
         cfg(2'h2, 16'h0000, 16'h2000, 1'b1, 1'b0, 16'h0000, 4'h2, 4'h5);
         cfg_wr_i <= 1'b0;
         cyc(1);
         hl_watch = 1'b1;
         burst_chk = (m == 0);
         run = 0;
         bursts = 0;
         run_cnt(4'h4, 400);
         hl_watch = 1'b0;
         burst_chk = 1'b0;
         `CHK("grants", 1'b1, cnt[2] >= 10)
      end
      wrap_up();
   end
endmodule : bwr_regulator_tb
`default_nettype wire
